// ==== hw/smc_consts.vh ====
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH

// ==========================================================
// register offsets
`define SMC_ADDR_COMMIT 8'h00
`define SMC_ADDR_REF 8'h0a
`define SMC_ADDR_SYNTH_PWR 8'h0c
`define SMC_ADDR_LOCK_B 8'h0d
`define SMC_ADDR_TRANSMIT_DISABLE_INPUT 8'h0e
`define SMC_ADDR_LOCK_A 8'h17
`define SMC_ADDR_AUTOCAL 8'h18
`define SMC_ADDR_AC_TIMER 8'h19
`define SMC_ADDR_LO_MON 8'h1b
`define SMC_ADDR_RF_DIV 8'h1c
`define SMC_ADDR_MOD_PWR 8'h1d
`define SMC_ADDR_ATTEN 8'h1e
`define SMC_ADDR_REVISION 8'h21

// ==========================================================
// field positions
`define SMC_REF_HALVE_BIT 6
`define SMC_REF_DOUBLER_BIT 5
`define SMC_REF_DIV_MSB 4
`define SMC_SYNTH_PD_BIT 2
`define SMC_LOCK_CNT_HI_BIT 6
`define SMC_STOP_LO_BIT 7
`define SMC_LOCK_EN_BIT 4
`define SMC_LOCK_CNT_LO_BIT 3
`define SMC_LOCK_FINE_BIT 2
`define SMC_AUTOCAL_OFF_BIT 0
`define SMC_VCO_RANGE_BIT 4
`define SMC_LO_MON_EN_BIT 2
`define SMC_LO_MON_PWR_MSB 1
`define SMC_RF_DIV_PD_BIT 4
`define SMC_RF_DIV_MSB 2
`define SMC_MOD_EN_BIT 0
`define SMC_ATTEN_MSB 5

// ==========================================================
// reset and decode values
`define SMC_RST_BYTE 8'h00
`define SMC_REF_DIV_ZERO_RATIO 6'h20
`define SMC_ATTEN_HIGH_BASE 2'h2

// ==========================================================
// lock window widths in ns
`define SMC_LOCK_COARSE_NS 10
`define SMC_LOCK_FINE_NS 6

`endif

// ==== hw/smc_dbl_buffer.v ====
`timescale 1ns/1ps

// ==========================================================
// shadow stage plus active stage for one double-buffered field
module smc_dbl_buffer #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // shadow side
    input wire load,
    input wire [WIDTH-1:0] din,
    // transfer strobe
    input wire commit,
    // stages
    output reg [WIDTH-1:0] shadow_reg,
    output reg [WIDTH-1:0] active_reg
);

    // shadow takes writes, active only moves on commit
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            shadow_reg <= {WIDTH{1'b0}};
            active_reg <= {WIDTH{1'b0}};
        end
        else
        begin
            if (load)
                shadow_reg <= din;
            // a load in the same cycle is carried straight through
            if (commit)
                active_reg <= load ? din : shadow_reg;
        end
    end

endmodule

// ==== hw/smc_atten_decode.v ====
`timescale 1ns/1ps
`include "smc_consts.vh"

// ==========================================================
// attenuator code to dB step count
module smc_atten_decode (
    // raw code
    input wire [5:0] code,
    // decoded attenuation
    output reg [5:0] atten_db,
    output reg code_ok
);

    // low half maps 1:1, top quarter adds 32 dB on its low nibble
    always @*
    begin
        if (!code[5])
        begin
            atten_db = {1'b0, code[4:0]};
            code_ok = 1'b1;
        end
        else
        begin
            atten_db = {`SMC_ATTEN_HIGH_BASE, code[3:0]};
            // 10xxxx has no defined step
            code_ok = code[4];
        end
    end

endmodule

// ==== hw/smc_regs.v ====
`timescale 1ns/1ps
`include "smc_consts.vh"

// Operation
// RQ1 - double-buffered fields apply on commit write
// RQ2 - ref bit 6 selects halving divider
// RQ3 - ref bit 5 enables frequency doubler
// RQ4 - ref divide code, zero means 32
// RQ5 - synth power bit 2 powers down
// RQ6 - stop lo clock while tx disabled
// RQ7 - lock bit 4 enables lock detector
// RQ8 - lock count split over two registers
// RQ9 - lock precision bit picks window
// RQ10 - autocal bit 0 disables calibration
// RQ11 - autocal timer eight bit value
// RQ12 - lo monitor bit 2 powers up
// RQ13 - lo monitor power two bit select
// RQ14 - software sets vco range bit
// RQ15 - rf divider powerdown and buffered select
// RQ16 - modulator power bit, bit 7 one
// RQ17 - six bit attenuator code in dB
// RQ18 - revision register read only
// RQ19 - software writes fixed bits correctly
// RQ20 - software writes commit register last
module smc_regs #(
    // arbitrary value, not tied to any real part
    parameter [7:0] REVISION_CODE = 8'h5a
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // register port from the serial decoder
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    output reg rd_valid,
    // transmit disable pin
    input wire transmit_disable_input,
    // reference path
    output reg ref_halve_en,
    output reg ref_doubler_en,
    output reg [5:0] ref_div_ratio,
    // synthesizer
    output reg synth_power_down,
    output reg new_acquisition,
    output reg lo_clock_stop,
    // lock detector
    output reg lock_det_en,
    output reg [1:0] lock_count,
    output reg lock_fine_window,
    // autocalibration
    output reg autocal_en,
    output reg [7:0] autocal_timer_value,
    // lo monitor and range
    output reg lo_mon_power_up,
    output reg [1:0] lo_mon_power_sel,
    output reg vco_range_sel,
    // rf output divider
    output reg rf_output_divider_pd,
    output reg [2:0] rf_divide_select,
    // modulator and attenuator
    output reg modulator_power_up,
    output reg [5:0] attenuation_db,
    output reg attenuation_code_ok
);

    // ==========================================================
    // write decode
    wire wr_commit = wr_en && (addr == `SMC_ADDR_COMMIT);
    wire wr_ref = wr_en && (addr == `SMC_ADDR_REF);
    wire wr_rf_divide_select = wr_en && (addr == `SMC_ADDR_RF_DIV);

    // plain registers
    reg [7:0] synth_power_control_reg;
    reg [7:0] lock_detect_control_b_reg;
    reg [7:0] tx_disable_clock_control_reg;
    reg [7:0] lock_detect_control_a_reg;
    reg [7:0] autocal_control_reg;
    reg [7:0] autocal_timer_reg;
    reg [7:0] lo_monitor_and_range_reg;
    reg [7:0] lo_output_divider_hi_reg;
    reg [7:0] modulator_power_reg;
    reg [7:0] output_attenuation_reg;

    // double-buffered stages
    wire [7:0] ref_shadow;
    wire [7:0] ref_active;
    wire [2:0] rf_divide_select_shadow;
    wire [2:0] rf_divide_select_active;

    // pin synchroniser
    reg transmit_disable_input_meta_reg;
    reg transmit_disable_input_sync_reg;

    // decoded attenuator
    wire [5:0] atten_db_next;
    wire atten_ok_next;

    // ==========================================================
    // double-buffered fields
    // RQ1 shadow then commit
    smc_dbl_buffer #(
        .WIDTH(8)
    ) u_ref_buf (
        .clk(clk),
        .resetn(resetn),
        .load(wr_ref),
        .din(wr_data),
        .commit(wr_commit),
        .shadow_reg(ref_shadow),
        .active_reg(ref_active)
    );

    // RQ15 buffered divide select
    smc_dbl_buffer #(
        .WIDTH(3)
    ) u_rf_divide_select_buf (
        .clk(clk),
        .resetn(resetn),
        .load(wr_rf_divide_select),
        .din(wr_data[`SMC_RF_DIV_MSB:0]),
        .commit(wr_commit),
        .shadow_reg(rf_divide_select_shadow),
        .active_reg(rf_divide_select_active)
    );

    // ==========================================================
    // immediate registers
    // RQ18 revision has no storage, so writes there fall away
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            synth_power_control_reg <= `SMC_RST_BYTE;
            lock_detect_control_b_reg <= `SMC_RST_BYTE;
            tx_disable_clock_control_reg <= `SMC_RST_BYTE;
            lock_detect_control_a_reg <= `SMC_RST_BYTE;
            autocal_control_reg <= `SMC_RST_BYTE;
            autocal_timer_reg <= `SMC_RST_BYTE;
            lo_monitor_and_range_reg <= `SMC_RST_BYTE;
            lo_output_divider_hi_reg <= `SMC_RST_BYTE;
            modulator_power_reg <= `SMC_RST_BYTE;
            output_attenuation_reg <= `SMC_RST_BYTE;
        end
        else if (wr_en)
        begin
            case (addr)
                `SMC_ADDR_SYNTH_PWR: synth_power_control_reg <= wr_data;
                `SMC_ADDR_LOCK_B: lock_detect_control_b_reg <= wr_data;
                `SMC_ADDR_TRANSMIT_DISABLE_INPUT: tx_disable_clock_control_reg <= wr_data;
                `SMC_ADDR_LOCK_A: lock_detect_control_a_reg <= wr_data;
                `SMC_ADDR_AUTOCAL: autocal_control_reg <= wr_data;
                `SMC_ADDR_AC_TIMER: autocal_timer_reg <= wr_data;
                `SMC_ADDR_LO_MON: lo_monitor_and_range_reg <= wr_data;
                // low three bits live in the double buffer
                `SMC_ADDR_RF_DIV:
                    lo_output_divider_hi_reg <= {wr_data[7:3], 3'h0};
                `SMC_ADDR_MOD_PWR: modulator_power_reg <= wr_data;
                `SMC_ADDR_ATTEN: output_attenuation_reg <= wr_data;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // transmit disable pin, two flops before use
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            transmit_disable_input_meta_reg <= 1'b0;
            transmit_disable_input_sync_reg <= 1'b0;
        end
        else
        begin
            transmit_disable_input_meta_reg <= transmit_disable_input;
            transmit_disable_input_sync_reg <= transmit_disable_input_meta_reg;
        end
    end

    // ==========================================================
    // attenuator decode
    // RQ17 code to dB
    smc_atten_decode u_atten (
        .code(output_attenuation_reg[`SMC_ATTEN_MSB:0]),
        .atten_db(atten_db_next),
        .code_ok(atten_ok_next)
    );

    // ==========================================================
    // control outputs, each from its own flop
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            ref_halve_en <= 1'b0;
            ref_doubler_en <= 1'b0;
            ref_div_ratio <= `SMC_REF_DIV_ZERO_RATIO;
            synth_power_down <= 1'b0;
            new_acquisition <= 1'b0;
            lo_clock_stop <= 1'b0;
            lock_det_en <= 1'b0;
            lock_count <= 2'h0;
            lock_fine_window <= 1'b0;
            autocal_en <= 1'b1;
            autocal_timer_value <= 8'h00;
            lo_mon_power_up <= 1'b0;
            lo_mon_power_sel <= 2'h0;
            vco_range_sel <= 1'b0;
            rf_output_divider_pd <= 1'b0;
            rf_divide_select <= 3'h0;
            modulator_power_up <= 1'b0;
            attenuation_db <= 6'h00;
            attenuation_code_ok <= 1'b1;
        end
        else
        begin
            // RQ2 halving divider select
            ref_halve_en <= ref_active[`SMC_REF_HALVE_BIT];
            // RQ3 doubler enable
            ref_doubler_en <= ref_active[`SMC_REF_DOUBLER_BIT];
            // RQ4 zero code means 32
            if (ref_active[`SMC_REF_DIV_MSB:0] == 5'h00)
                ref_div_ratio <= `SMC_REF_DIV_ZERO_RATIO;
            else
                ref_div_ratio <= {1'b0, ref_active[`SMC_REF_DIV_MSB:0]};
            // RQ5 synth power down
            synth_power_down <=
                synth_power_control_reg[`SMC_SYNTH_PD_BIT];
            // RQ20 commit restarts acquisition
            new_acquisition <= wr_commit;
            // RQ6 gate lo clock on pin
            lo_clock_stop <= transmit_disable_input_sync_reg &
                tx_disable_clock_control_reg[`SMC_STOP_LO_BIT];
            // RQ7 lock detector enable
            lock_det_en <= lock_detect_control_a_reg[`SMC_LOCK_EN_BIT];
            // RQ8 high bit from one register, low from the other
            lock_count <= {
                lock_detect_control_b_reg[`SMC_LOCK_CNT_HI_BIT],
                lock_detect_control_a_reg[`SMC_LOCK_CNT_LO_BIT]};
            // RQ9 fine window when set
            lock_fine_window <=
                lock_detect_control_a_reg[`SMC_LOCK_FINE_BIT];
            // RQ10 bit set turns calibration off
            autocal_en <= !autocal_control_reg[`SMC_AUTOCAL_OFF_BIT];
            // RQ11 calibration duration
            autocal_timer_value <= autocal_timer_reg;
            // RQ12 monitor power up
            lo_mon_power_up <=
                lo_monitor_and_range_reg[`SMC_LO_MON_EN_BIT];
            // RQ13 monitor level select
            lo_mon_power_sel <=
                lo_monitor_and_range_reg[`SMC_LO_MON_PWR_MSB:0];
            // RQ14 range bit passed as written
            vco_range_sel <=
                lo_monitor_and_range_reg[`SMC_VCO_RANGE_BIT];
            // RQ15 divider power down immediate
            rf_output_divider_pd <=
                lo_output_divider_hi_reg[`SMC_RF_DIV_PD_BIT];
            rf_divide_select <= rf_divide_select_active;
            // RQ16 modulator power up
            modulator_power_up <= modulator_power_reg[`SMC_MOD_EN_BIT];
            attenuation_db <= atten_db_next;
            attenuation_code_ok <= atten_ok_next;
        end
    end

    // ==========================================================
    // readback, one cycle after the request
    // double-buffered registers show the pending shadow value
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (rd_en)
            begin
                case (addr)
                    `SMC_ADDR_REF: rd_data <= ref_shadow;
                    `SMC_ADDR_SYNTH_PWR: rd_data <= synth_power_control_reg;
                    `SMC_ADDR_LOCK_B: rd_data <= lock_detect_control_b_reg;
                    `SMC_ADDR_TRANSMIT_DISABLE_INPUT:
                        rd_data <= tx_disable_clock_control_reg;
                    `SMC_ADDR_LOCK_A: rd_data <= lock_detect_control_a_reg;
                    `SMC_ADDR_AUTOCAL: rd_data <= autocal_control_reg;
                    `SMC_ADDR_AC_TIMER: rd_data <= autocal_timer_reg;
                    `SMC_ADDR_LO_MON: rd_data <= lo_monitor_and_range_reg;
                    `SMC_ADDR_RF_DIV:
                        rd_data <= lo_output_divider_hi_reg | {5'h00,
                            rf_divide_select_shadow};
                    `SMC_ADDR_MOD_PWR: rd_data <= modulator_power_reg;
                    `SMC_ADDR_ATTEN: rd_data <= output_attenuation_reg;
                    // RQ18 fixed revision code
                    `SMC_ADDR_REVISION: rd_data <= REVISION_CODE;
                    // commit and unmapped addresses read back as zero
                    default: rd_data <= 8'h00;
                endcase
            end
        end
    end

endmodule

// ==== test/smc_regs_chk.sv ====
`timescale 1ns/1ps

// ==========================================================
// register bank checker, port side only
module smc_regs_chk #(
    parameter [7:0] REVISION_CODE = 8'h5a
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // register port
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_data,
    input wire rd_valid,
    // watched controls
    input wire transmit_disable_input,
    input wire ref_halve_en,
    input wire ref_doubler_en,
    input wire [5:0] ref_div_ratio,
    input wire new_acquisition,
    input wire lo_clock_stop,
    input wire autocal_en,
    input wire [7:0] autocal_timer_value,
    input wire [2:0] rf_divide_select,
    input wire modulator_power_up,
    input wire [5:0] attenuation_db,
    input wire attenuation_code_ok
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // buffered fields may only move two edges after a commit write
    commit_pulse_a: assert property (
        wr_en && addr == 8'h00 |=> new_acquisition)
        else $error("no acquisition pulse after commit");
    acq_cause_a: assert property (
        new_acquisition |-> $past(wr_en) && $past(addr) == 8'h00)
        else $error("acquisition pulse without commit");
    ref_hold_a: assert property (
        $changed({ref_halve_en, ref_doubler_en, ref_div_ratio,
        rf_divide_select}) |-> $past(wr_en, 2) && $past(addr, 2) == 8'h00)
        else $error("buffered field moved without commit");
    // pin passes two sync flops and one output flop
    lo_stop_a: assert property (
        lo_clock_stop |-> $past(transmit_disable_input, 3))
        else $error("lo clock stopped while pin low");
    autocal_a: assert property (
        wr_en && addr == 8'h18 |=> ##1 autocal_en != $past(wr_data[0], 2))
        else $error("autocal enable wrong after write");
    timer_a: assert property (
        wr_en && addr == 8'h19 |=> ##1 autocal_timer_value ==
        $past(wr_data, 2))
        else $error("autocal timer wrong after write");
    atten_high_a: assert property (
        wr_en && addr == 8'h1e && wr_data[5:4] == 2'h3 |=> ##1
        attenuation_code_ok && attenuation_db == {2'h2, $past(wr_data[3:0], 2)})
        else $error("upper attenuation code decoded wrong");
    mod_power_a: assert property (
        wr_en && addr == 8'h1d |=> ##1 modulator_power_up ==
        $past(wr_data[0], 2))
        else $error("modulator power wrong after write");
    rev_read_a: assert property (
        rd_en && addr == 8'h21 |=> rd_valid && rd_data == REVISION_CODE)
        else $error("revision read wrong");
endmodule

bind smc_regs smc_regs_chk #(.REVISION_CODE(REVISION_CODE)) chk_i (
    .clk(clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .transmit_disable_input(transmit_disable_input),
    .ref_halve_en(ref_halve_en), .ref_doubler_en(ref_doubler_en),
    .ref_div_ratio(ref_div_ratio), .new_acquisition(new_acquisition),
    .lo_clock_stop(lo_clock_stop), .autocal_en(autocal_en),
    .autocal_timer_value(autocal_timer_value),
    .rf_divide_select(rf_divide_select),
    .modulator_power_up(modulator_power_up),
    .attenuation_db(attenuation_db),
    .attenuation_code_ok(attenuation_code_ok)
);

// ==== test/synth_modulator_control_regs_test.sv ====
`timescale 1ns/1ps

module synth_modulator_control_regs_test;
    // arbitrary value, not tied to any real part
    localparam [7:0] REV = 8'h3c;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wr_data = 8'h00;
    reg transmit_disable_input = 1'b0;
    wire [7:0] rd_data, autocal_timer_value;
    wire rd_valid, ref_halve_en, ref_doubler_en, synth_power_down;
    wire new_acquisition, lo_clock_stop, lock_det_en, lock_fine_window;
    wire autocal_en, lo_mon_power_up, vco_range_sel, rf_output_divider_pd;
    wire modulator_power_up, attenuation_code_ok;
    wire [5:0] ref_div_ratio, attenuation_db;
    wire [1:0] lock_count, lo_mon_power_sel;
    wire [2:0] rf_divide_select;
    integer bad_count = 0;
    integer n_checks = 0;
    integer i;

    // ==========================================================
    // clock and design
    initial
    begin
        forever #25 clk = ~clk;
    end

    smc_regs #(.REVISION_CODE(REV)) uut (
        .clk(clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .transmit_disable_input(transmit_disable_input),
        .ref_halve_en(ref_halve_en), .ref_doubler_en(ref_doubler_en),
        .ref_div_ratio(ref_div_ratio), .synth_power_down(synth_power_down),
        .new_acquisition(new_acquisition), .lo_clock_stop(lo_clock_stop),
        .lock_det_en(lock_det_en), .lock_count(lock_count),
        .lock_fine_window(lock_fine_window), .autocal_en(autocal_en),
        .autocal_timer_value(autocal_timer_value),
        .lo_mon_power_up(lo_mon_power_up),
        .lo_mon_power_sel(lo_mon_power_sel), .vco_range_sel(vco_range_sel),
        .rf_output_divider_pd(rf_output_divider_pd),
        .rf_divide_select(rf_divide_select),
        .modulator_power_up(modulator_power_up),
        .attenuation_db(attenuation_db),
        .attenuation_code_ok(attenuation_code_ok)
    );

    // ==========================================================
    // access tasks
    task chk(input [7:0] act, input [7:0] exp);
    begin
        n_checks = n_checks + 1;
        if (act !== exp)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h want %h", $time, act, exp);
        end
    end
    endtask

    // returns once derived outputs have settled
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
        #1;
    end
    endtask

    // read answer is due exactly one edge after the strobe
    task rdchk(input [7:0] a, input [7:0] exp);
    begin
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk({7'h00, rd_valid}, 8'h01);
        chk(rd_data, exp);
    end
    endtask

    // commit write, then the one-cycle acquisition pulse
    task commit;
    begin
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= 8'h00;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
        chk({7'h00, new_acquisition}, 8'h01);
        @(posedge clk);
        #1;
        chk({7'h00, new_acquisition}, 8'h00);
    end
    endtask

    task refchk(input [7:0] d, input [7:0] exp);
    begin
        wr(8'h0a, d);
        commit;
        chk({ref_halve_en, ref_doubler_en, ref_div_ratio}, exp);
    end
    endtask

    task end_sim;
    begin
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk({ref_halve_en, ref_doubler_en, ref_div_ratio}, 8'h20);
        chk({synth_power_down, lock_det_en, lock_count, lock_fine_window,
            autocal_en, modulator_power_up, rf_output_divider_pd}, 8'h04);
        chk({lo_mon_power_up, lo_mon_power_sel, rf_divide_select,
            attenuation_code_ok, lo_clock_stop}, 8'h02);
        // shadow holds until commit, read shows pending value
        wr(8'h0a, 8'h65);
        chk({ref_halve_en, ref_doubler_en, ref_div_ratio}, 8'h20);
        rdchk(8'h0a, 8'h65);
        commit;
        chk({ref_halve_en, ref_doubler_en, ref_div_ratio}, 8'hc5);
        refchk(8'h1f, 8'h1f);
        refchk(8'h01, 8'h01);
        refchk(8'h40, 8'ha0);
        refchk(8'h20, 8'h60);
        // divider power acts at once, divide select waits for commit
        wr(8'h1c, 8'h1b);
        chk({rf_output_divider_pd, rf_divide_select}, 8'h08);
        rdchk(8'h1c, 8'h1b);
        commit;
        chk({rf_output_divider_pd, rf_divide_select}, 8'h0b);
        wr(8'h0c, 8'h1c);
        chk({7'h00, synth_power_down}, 8'h01);
        // fixed bits 6 and 5 written as one
        wr(8'h17, 8'h7c);
        chk({lock_det_en, lock_count, lock_fine_window}, 8'h0b);
        wr(8'h0d, 8'he8);
        chk({lock_det_en, lock_count, lock_fine_window}, 8'h0f);
        wr(8'h17, 8'h60);
        chk({lock_det_en, lock_count, lock_fine_window}, 8'h04);
        wr(8'h18, 8'h19);
        chk({7'h00, autocal_en}, 8'h00);
        wr(8'h19, 8'h64);
        chk(autocal_timer_value, 8'h64);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h1b, 8'h14 | i[7:0]);
            chk({lo_mon_power_up, vco_range_sel, lo_mon_power_sel},
                8'h0c | i[7:0]);
        end
        // low band: range bit cleared by software
        wr(8'h1b, 8'h04);
        chk({lo_mon_power_up, vco_range_sel, lo_mon_power_sel},
            8'h08);
        wr(8'h1d, 8'h81);
        chk({7'h00, modulator_power_up}, 8'h01);
        rdchk(8'h1d, 8'h81);
        wr(8'h1e, 8'h1f);
        chk({attenuation_code_ok, attenuation_db}, 8'h5f);
        wr(8'h1e, 8'h30);
        chk({attenuation_code_ok, attenuation_db}, 8'h60);
        wr(8'h1e, 8'h3f);
        chk({attenuation_code_ok, attenuation_db}, 8'h6f);
        wr(8'h1e, 8'h20);
        chk({attenuation_code_ok, attenuation_db}, 8'h20);
        // read-only and unmapped places
        wr(8'h21, 8'hff);
        rdchk(8'h21, REV);
        rdchk(8'h15, 8'h00);
        // pin only stops the clock while the enable bit is set
        @(posedge clk);
        transmit_disable_input <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({7'h00, lo_clock_stop}, 8'h00);
        wr(8'h0e, 8'h80);
        chk({7'h00, lo_clock_stop}, 8'h01);
        @(posedge clk);
        transmit_disable_input <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk({7'h00, lo_clock_stop}, 8'h00);
        // second reset in mid-run
        @(posedge clk);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk({ref_div_ratio, autocal_en, modulator_power_up}, 8'h82);
        end_sim;
    end
endmodule
